// file: inc/crcu_pkg.sv
// Constants shared by the checksum unit: register map, control fields, polynomials, reset values.
package crcu_pkg;

    localparam logic [11:0] CRCU_OFF_CTRL   = 12'h000;
    localparam logic [11:0] CRCU_OFF_SEED   = 12'h004;
    localparam logic [11:0] CRCU_OFF_SUM    = 12'h008;
    localparam logic [11:0] CRCU_OFF_DATA8  = 12'h00C;
    localparam logic [11:0] CRCU_OFF_DATA16 = 12'h010;
    localparam logic [11:0] CRCU_OFF_DATA32 = 12'h014;
    localparam logic [11:0] CRCU_OFF_STATUS = 12'h018;

    localparam int CRCU_CTRL_MODE_LSB  = 0;
    localparam int CRCU_CTRL_DCMPL     = 2;
    localparam int CRCU_CTRL_DBYTE_REV = 3;
    localparam int CRCU_CTRL_DBIT_REV  = 4;
    localparam int CRCU_CTRL_SCMPL     = 5;
    localparam int CRCU_CTRL_SBYTE_REV = 6;
    localparam int CRCU_CTRL_SBIT_REV  = 7;

    localparam logic [1:0] CRCU_MODE_C16   = 2'h0;
    localparam logic [1:0] CRCU_MODE_CCITT = 2'h1;
    localparam logic [1:0] CRCU_MODE_C32   = 2'h2;

    localparam logic [15:0] CRCU_POLY_C16   = 16'h8005;
    localparam logic [15:0] CRCU_POLY_CCITT = 16'h1021;
    localparam logic [31:0] CRCU_POLY_C32   = 32'h04C11DB7;

    localparam logic [7:0]  CRCU_CTRL_RST = 8'h00;
    localparam logic [31:0] CRCU_CRC_RST  = 32'h00000000;

endpackage

// file: rtl/crcu_top.sv
// Checksum engine with an APB register slave, one byte folded per clock.
// What this block does
// - Offers a 16-bit checksum mode with generator 0x8005.
// - Offers a 16-bit checksum mode with CCITT generator 0x1021.
// - Offers a 32-bit checksum mode with generator 0x04C11DB7.
// - Complement, byte reversal, bit reversal selectable separately on data and checksum.
// - Byte, half-word and word data writes all fold into the remainder.
// - Software loads a seed; computation starts from it.
// - Byte write done within 1 cycle, word write within 4 cycles.
// - Remainder reads 16 bits wide in 16-bit modes, 32 bits in 32-bit mode.
//
// Our own choices: the register addresses and the APB slave port.
module crcu_top
    import crcu_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [31:0] crc;
        logic [23:0] pend;
        logic [1:0]  cnt;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } crcu_state_s;

    crcu_state_s st_r;
    crcu_state_s st_nxt;
    logic        acc;
    logic        is_data;
    logic        is_map;
    logic [2:0]  nbytes;
    logic [31:0] dat;

    // Folds one byte, most significant bit first, into the remainder.
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b,
                                             input logic [1:0] m);
        logic [31:0] r;
        logic        fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = ((m == CRCU_MODE_C32) ? r[31] : r[15]) ^ b[i];
            r  = {r[30:0], 1'b0};
            if (fb) begin
                if (m == CRCU_MODE_C32) begin
                    r = r ^ CRCU_POLY_C32;
                end else if (m == CRCU_MODE_CCITT) begin
                    r = r ^ {16'h0000, CRCU_POLY_CCITT};
                end else begin
                    r = r ^ {16'h0000, CRCU_POLY_C16};
                end
            end
        end
        if (m != CRCU_MODE_C32) begin
            r[31:16] = 16'h0000;
        end
        return r;
    endfunction

    // Applies the data transformations within the written size.
    function automatic logic [31:0] data_xform(input logic [31:0] d, input logic [2:0] n,
                                               input logic [7:0] c);
        logic [31:0] r;
        r = d;
        if (c[CRCU_CTRL_DCMPL]) begin
            r = ~r;
        end
        if (c[CRCU_CTRL_DBYTE_REV]) begin
            if (n == 3'h4) begin
                r = {r[7:0], r[15:8], r[23:16], r[31:24]};
            end else if (n == 3'h2) begin
                r = {r[31:16], r[7:0], r[15:8]};
            end
        end
        if (c[CRCU_CTRL_DBIT_REV]) begin
            for (int k = 0; k < 4; k++) begin
                r[8*k +: 8] = {<<{r[8*k +: 8]}};
            end
        end
        return r;
    endfunction

    // Presents the remainder at its mode's width with the checksum transformations.
    function automatic logic [31:0] sum_xform(input logic [31:0] s, input logic [7:0] c);
        logic [31:0] r;
        logic [15:0] h;
        logic        w32;
        r   = s;
        h   = s[15:0];
        w32 = (c[1:0] == CRCU_MODE_C32);
        if (c[CRCU_CTRL_SBIT_REV]) begin
            // A bit stream may only feed a whole assignment, so each width reverses on its own.
            if (w32) begin
                r = {<<{s}};
            end else begin
                h = {<<{s[15:0]}};
                r = {16'h0000, h};
            end
        end
        if (c[CRCU_CTRL_SBYTE_REV]) begin
            r = w32 ? {r[7:0], r[15:8], r[23:16], r[31:24]} : {16'h0000, r[7:0], r[15:8]};
        end
        if (c[CRCU_CTRL_SCMPL]) begin
            r = ~r;
        end
        if (!w32) begin
            r[31:16] = 16'h0000;
        end
        return r;
    endfunction

    always_comb begin
        st_nxt  = st_r;
        acc     = psel && penable;
        is_data = 1'b0;
        is_map  = 1'b1;
        nbytes  = 3'h1;
        if (paddr == CRCU_OFF_DATA8) begin
            is_data = 1'b1;
        end else if (paddr == CRCU_OFF_DATA16) begin
            is_data = 1'b1;
            nbytes  = 3'h2;
        end else if (paddr == CRCU_OFF_DATA32) begin
            is_data = 1'b1;
            nbytes  = 3'h4;
        end else if (paddr != CRCU_OFF_CTRL && paddr != CRCU_OFF_SEED
                     && paddr != CRCU_OFF_SUM && paddr != CRCU_OFF_STATUS) begin
            is_map = 1'b0;
        end
        dat = data_xform(pwdata, nbytes, st_r.ctrl);
        // Remaining bytes drain one per cycle behind the bus.
        if (st_r.cnt != 2'h0) begin
            st_nxt.crc  = crc_byte(st_r.crc, st_r.pend[7:0], st_r.ctrl[1:0]);
            st_nxt.pend = {8'h00, st_r.pend[23:8]};
            st_nxt.cnt  = st_r.cnt - 2'h1;
        end
        if (acc && !st_r.pready) begin
            // Data and checksum accesses stall while bytes are still pending.
            if (!((is_data || paddr == CRCU_OFF_SUM) && st_r.cnt != 2'h0)) begin
                st_nxt.pready  = 1'b1;
                st_nxt.pslverr = !is_map;
                st_nxt.prdata  = 32'h00000000;
                if (!pwrite) begin
                    if (paddr == CRCU_OFF_CTRL) begin
                        st_nxt.prdata = {24'h000000, st_r.ctrl};
                    end else if (paddr == CRCU_OFF_SEED) begin
                        st_nxt.prdata = st_r.crc;
                    end else if (paddr == CRCU_OFF_SUM) begin
                        st_nxt.prdata = sum_xform(st_r.crc, st_r.ctrl);
                    end else if (paddr == CRCU_OFF_STATUS) begin
                        st_nxt.prdata = {31'h00000000, (st_r.cnt != 2'h0)};
                    end
                end
            end
        end else if (acc && st_r.pready) begin
            st_nxt.pready  = 1'b0;
            st_nxt.pslverr = 1'b0;
            if (pwrite && is_map) begin
                if (paddr == CRCU_OFF_CTRL) begin
                    st_nxt.ctrl = pwdata[7:0];
                end else if (paddr == CRCU_OFF_SEED) begin
                    st_nxt.crc = (st_r.ctrl[1:0] == CRCU_MODE_C32) ? pwdata
                                 : {16'h0000, pwdata[15:0]};
                    st_nxt.cnt = 2'h0;
                end else if (is_data) begin
                    // First byte folds at the completing edge, the rest drain after it.
                    st_nxt.crc  = crc_byte(st_r.crc, dat[7:0], st_r.ctrl[1:0]);
                    st_nxt.pend = dat[31:8];
                    st_nxt.cnt  = nbytes[1:0] - 2'h1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '{ctrl: CRCU_CTRL_RST, crc: CRCU_CRC_RST, pend: 24'h000000, cnt: 2'h0,
                      pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata  = st_r.prdata;
    assign pready  = st_r.pready;
    assign pslverr = st_r.pslverr;

    // A byte 0x01 folded into a zero remainder with no data options leaves the generator.
    sequence s_one_byte(logic [1:0] m);
        acc && st_r.pready && pwrite && paddr == CRCU_OFF_DATA8 && pwdata[7:0] == 8'h01
            && st_r.crc == 32'h00000000 && st_r.ctrl[4:0] == {3'h0, m};
    endsequence

    sequence s_data_wr(logic [11:0] a);
        acc && st_r.pready && pwrite && paddr == a;
    endsequence

    a_poly_c16: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_one_byte(CRCU_MODE_C16) |=> st_r.crc == 32'h00008005)
        else $error("16-bit mode generator wrong.");

    a_poly_ccitt: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_one_byte(CRCU_MODE_CCITT) |=> st_r.crc == 32'h00001021)
        else $error("CCITT mode generator wrong.");

    a_poly_c32: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_one_byte(CRCU_MODE_C32) |=> st_r.crc == 32'h04C11DB7)
        else $error("32-bit mode generator wrong.");

    a_sum_cmpl: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        acc && !st_r.pready && !pwrite && paddr == CRCU_OFF_SUM && st_r.cnt == 2'h0
            && st_r.ctrl == 8'h20
        |=> st_r.pready && st_r.prdata == {16'h0000, ~$past(st_r.crc[15:0])})
        else $error("Checksum complement wrong.");

    a_byte_fold: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_data_wr(CRCU_OFF_DATA8) |=> st_r.cnt == 2'h0 && !st_r.pready)
        else $error("Byte write left work pending.");

    a_seed_load: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_data_wr(CRCU_OFF_SEED) ##0 st_r.ctrl[1:0] == CRCU_MODE_C32
        |=> st_r.crc == $past(pwdata))
        else $error("Seed not loaded.");

    a_word_time: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_data_wr(CRCU_OFF_DATA32) |=> st_r.cnt == 2'h3 ##3 st_r.cnt == 2'h0)
        else $error("Word write not done in four cycles.");

    a_sum_width: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        acc && !st_r.pready && !pwrite && paddr == CRCU_OFF_SUM && st_r.cnt == 2'h0
            && st_r.ctrl[1:0] != CRCU_MODE_C32
        |=> st_r.prdata[31:16] == 16'h0000)
        else $error("16-bit checksum has upper bits set.");

    a_half_time: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        s_data_wr(CRCU_OFF_DATA16) |=> st_r.cnt == 2'h1 ##1 st_r.cnt == 2'h0)
        else $error("Half-word write not done in two cycles.");

    a_stall_busy: assert property (
        @(posedge core_clk) disable iff (!reset_n)
        acc && st_r.pready && (is_data || paddr == CRCU_OFF_SUM) |-> st_r.cnt == 2'h0)
        else $error("Access completed while busy.");

endmodule // crcu_top

// file: bench/crcu_apb_master.sv
// Processor-side APB master model that drives the checksum unit.
module crcu_apb_master (
    input  wire logic        core_clk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // Called just after a rising edge; the request is held until pready is sampled high.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input bit last, output logic [31:0] rd, output logic err);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // A call that is not the last hands the bus straight to the next setup cycle.
        if (last) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            // A released data bus must not keep looking valid to the slave.
            pwdata  <= ~d;
        end
    endtask
endmodule // crcu_apb_master

// file: bench/crc_calculation_unit_test.sv
// Self-checking testbench of the checksum unit with a reference model.
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module crc_calculation_unit_test
    import crcu_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic        core_clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          num_errors = 0, cmp_count = 0, cyc = 0, seed = 51073;

    crcu_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    crcu_apb_master i_mst (.core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic summarize();
        if (num_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // A hung handshake ends the run here instead of stalling forever.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            summarize();
        end
    end

    function automatic logic [31:0] fold(input logic [31:0] r, input logic [31:0] d,
                                         input int n, input logic [7:0] c);
        logic [31:0] p, t;
        logic        fb;
        int          w;
        w = (c[1:0] == CRCU_MODE_C32) ? 32 : 16;
        p = (c[1:0] == CRCU_MODE_C32) ? CRCU_POLY_C32 :
            (c[1:0] == CRCU_MODE_CCITT) ? {16'h0000, CRCU_POLY_CCITT} : {16'h0000, CRCU_POLY_C16};
        if (c[2]) d = ~d;
        t = d;
        if (c[3]) for (int k = 0; k < n; k++) t[8*k+:8] = d[8*(n-1-k)+:8];
        for (int k = 0; k < n; k++) for (int i = 7; i >= 0; i--) begin
            fb = r[w-1] ^ (c[4] ? t[8*k+7-i] : t[8*k+i]);
            r = {r[30:0], 1'b0} ^ (fb ? p : 32'h00000000);
        end
        return (w == 16) ? (r & 32'h0000FFFF) : r;
    endfunction

    function automatic logic [31:0] sum(input logic [31:0] r, input logic [7:0] c);
        logic [31:0] s, b;
        int          w;
        w = (c[1:0] == CRCU_MODE_C32) ? 32 : 16;
        s = r;
        b = r;
        if (c[7]) for (int i = 0; i < w; i++) s[i] = r[w-1-i];
        b = s;
        if (c[6]) for (int k = 0; k < w / 8; k++) s[8*k+:8] = b[8*(w/8-1-k)+:8];
        if (c[5]) s = ~s;
        return (w == 16) ? (s & 32'h0000FFFF) : s;
    endfunction

    initial begin
        logic [31:0] rd, r, d;
        logic        err;
        logic [7:0]  c;
        logic [11:0] a;
        int          n;
        reset_n = 1'b0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        i_mst.xfer(1'b0, CRCU_OFF_CTRL, 32'h0, 1'b0, rd, err);
        `CHK(rd, {24'h000000, CRCU_CTRL_RST})
        i_mst.xfer(1'b0, CRCU_OFF_SUM, 32'h0, 1'b0, rd, err);
        `CHK(rd, CRCU_CRC_RST)
        i_mst.xfer(1'b1, 12'h01C, 32'h000000FF, 1'b0, rd, err);
        `CHK(err, 1'b1)
        i_mst.xfer(1'b0, 12'h01C, 32'h0, 1'b1, rd, err);
        `CHK({err, rd}, {1'b1, 32'h00000000})
        @(posedge core_clk);
        // A single 0x01 byte into a zero remainder leaves exactly the generator behind.
        for (int m = 0; m < 3; m++) begin
            c = 8'(m);
            i_mst.xfer(1'b1, CRCU_OFF_CTRL, {24'h000000, c}, 1'b0, rd, err);
            i_mst.xfer(1'b1, CRCU_OFF_SEED, 32'h00000000, 1'b0, rd, err);
            i_mst.xfer(1'b1, CRCU_OFF_DATA8, 32'h00000001, 1'b0, rd, err);
            i_mst.xfer(1'b0, CRCU_OFF_SEED, 32'h0, 1'b0, rd, err);
            d = (m == 2) ? CRCU_POLY_C32
                : {16'h0000, (m == 1) ? CRCU_POLY_CCITT : CRCU_POLY_C16};
            `CHK(rd, d)
            i_mst.xfer(1'b1, CRCU_OFF_CTRL, {24'h000000, c | 8'h20}, 1'b0, rd, err);
            i_mst.xfer(1'b0, CRCU_OFF_SUM, 32'h0, 1'b1, rd, err);
            `CHK(rd, sum(fold(32'h00000000, 32'h00000001, 1, c), c | 8'h20))
            @(posedge core_clk);
        end
        for (int it = 0; it < 60; it++) begin
            c = 8'($random(seed));
            c[1:0] = 2'(it);
            r = $random(seed);
            i_mst.xfer(1'b1, CRCU_OFF_CTRL, {24'h000000, c}, 1'b0, rd, err);
            i_mst.xfer(1'b0, CRCU_OFF_CTRL, 32'h0, 1'b0, rd, err);
            `CHK(rd[7:0], c)
            i_mst.xfer(1'b1, CRCU_OFF_SEED, r, 1'b0, rd, err);
            if (c[1:0] != CRCU_MODE_C32) r = r & 32'h0000FFFF;
            repeat (1 + it % 4) begin
                n = 1 << ($unsigned($random(seed)) % 3);
                d = $random(seed);
                a = (n == 1) ? CRCU_OFF_DATA8 : (n == 2) ? CRCU_OFF_DATA16 : CRCU_OFF_DATA32;
                i_mst.xfer(1'b1, a, d, 1'b0, rd, err);
                r = fold(r, d, n, c);
                if ($random(seed) & 1) begin
                    i_mst.xfer(1'b0, CRCU_OFF_STATUS, 32'h0, 1'b0, rd, err);
                    `CHK(rd[0], 1'(n == 4))
                end
            end
            i_mst.xfer(1'b0, CRCU_OFF_SUM, 32'h0, 1'b0, rd, err);
            `CHK(rd, sum(r, c))
            i_mst.xfer(1'b0, CRCU_OFF_SEED, 32'h0, 1'b1, rd, err);
            `CHK(rd, r)
            @(posedge core_clk);
        end
        // A reset in mid-run must bring control and remainder back to their reset values.
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        i_mst.xfer(1'b0, CRCU_OFF_CTRL, 32'h0, 1'b0, rd, err);
        `CHK(rd, {24'h000000, CRCU_CTRL_RST})
        i_mst.xfer(1'b0, CRCU_OFF_SEED, 32'h0, 1'b1, rd, err);
        `CHK(rd, CRCU_CRC_RST)
        summarize();
    end
endmodule // crc_calculation_unit_test
